// File: rtl/pfl_pkg.sv
// Package: offsets, field layouts, timing and carriers of the status/fault flag bank
package pfl_pkg;

  // Register offsets on the byte access port
  localparam logic [7:0] LIVE_STATUS_OFS = 8'h00;
  localparam logic [7:0] UV_FLAGS_OFS    = 8'h01;
  localparam logic [7:0] OV_FLAGS_OFS    = 8'h02;

  // Values after reset and after a factory fuse reload
  localparam logic [7:0] LIVE_STATUS_RST = 8'h00;
  localparam logic [5:0] RAIL_FLAGS_RST  = 6'h00;
  localparam logic [5:0] RAIL_FLAGS_FUSE = 6'h00;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // Field positions inside the flag registers
  localparam int unsigned RAIL_FLD_LSB = 2;
  localparam int unsigned RAIL_FLD_MSB = 7;
  localparam logic [1:0]  RSVD_BITS    = 2'h0;

  // Deglitch timing of the input supply comparators
  localparam int unsigned DEGLITCH_NS   = 10000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_W    = 11;
  localparam logic [DEGLITCH_W-1:0] DEGLITCH_LAST = DEGLITCH_W'(DEGLITCH_CYC - 1);
  localparam int unsigned SUPPLY_CMPS   = 4;

  // Input supply comparators, order matches live status bits 7..4
  typedef struct packed {
    logic sys_monitor_level;
    logic supply_warning_level;
    logic good_overvoltage_level;
    logic input_overvoltage_level;
  } pfl_supply_cmp_t;

  // One bit per rail, order matches flag register bits 7..2
  typedef struct packed {
    logic rail1;
    logic rail2;
    logic rail3;
    logic rail4;
    logic linear1;
    logic linear2;
  } pfl_rails_t;

  // Live status register layout
  typedef struct packed {
    pfl_supply_cmp_t supply;
    logic            temp_warning_level;
    logic            temp_shutdown_level;
    logic            system_power_good;
    logic            fault_active;
  } pfl_live_status_t;

  // Byte request from the serial target engine
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfl_reg_req_t;

endpackage : pfl_pkg

// File: rtl/pfl_deglitch.sv
// Rising-edge deglitch filter for one comparator level
`timescale 1ns/10ps
module pfl_deglitch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw comparator and filtered level
  input  wire logic level_raw,
  output logic      level_filt
);

  logic [pfl_pkg::DEGLITCH_W-1:0] cnt_reg;
  logic [pfl_pkg::DEGLITCH_W-1:0] cnt_next;
  logic                           filt_reg;
  logic                           filt_next;
  logic                           cnt_done;

  // Rise needs an unbroken run of high samples; a fall passes at once
  assign cnt_done  = (cnt_reg == pfl_pkg::DEGLITCH_LAST);
  assign cnt_next  = !level_raw ? '0 :
                     cnt_done   ? cnt_reg :
                                  cnt_reg + 1'b1;
  assign filt_next = level_raw & (filt_reg | cnt_done);

  // Counter and filtered level
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign level_filt = filt_reg;

endmodule : pfl_deglitch

// File: rtl/pfl_status_flags.sv
// Live status and sticky rail fault flag registers of the power manager
// Function
// - Bit7 system monitor level, 10 us deglitched
// - Bit6 supply warning level, 10 us deglitched
// - Bit5 good overvoltage level, 10 us deglitched
// - Bit4 input overvoltage level, 10 us deglitched
// - Bit3 follows temperature warning comparator
// - Bit2 follows temperature shutdown comparator
// - Bit1 power good, zero when power bad
// - Bit0 shows any active fault live
// - Live status read-only, resets to zero
// - Undervoltage events latch sticky rail flags
// - Undervoltage flags hold after rail recovery
// - Overvoltage events latch sticky rail flags
// - Flag read returns value, then clears
// - Registers invalid while supply below lockout
// - Factory fuse reload restores fused values
`timescale 1ns/10ps
module pfl_status_flags (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Supply and temperature comparators
  input  wire pfl_pkg::pfl_supply_cmp_t  supply_cmp,
  input  wire logic                      temp_warning_level,
  input  wire logic                      temp_shutdown_level,
  input  wire logic                      supply_lockout,
  // Sequencer state
  input  wire logic                      system_power_good,
  input  wire logic                      power_bad,
  input  wire logic                      fault_active,
  // Rail event pulses or levels
  input  wire pfl_pkg::pfl_rails_t       uv_event,
  input  wire pfl_pkg::pfl_rails_t       ov_event,
  // Factory fuse reload strobe
  input  wire logic                      factory_fuse_load,
  // Byte access port from the serial target engine
  input  wire pfl_pkg::pfl_reg_req_t     reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  output logic                           regs_valid
);

  pfl_pkg::pfl_supply_cmp_t  supply_filt;
  pfl_pkg::pfl_live_status_t live_reg;
  pfl_pkg::pfl_live_status_t live_next;
  pfl_pkg::pfl_rails_t       uv_reg;
  pfl_pkg::pfl_rails_t       uv_next;
  pfl_pkg::pfl_rails_t       ov_reg;
  pfl_pkg::pfl_rails_t       ov_next;
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      rvalid_reg;
  logic                      valid_reg;
  logic                      rd_live;
  logic                      rd_uv;
  logic                      rd_ov;
  logic [7:0]                uv_word;
  logic [7:0]                ov_word;
  logic [5:0]                uv_clr;
  logic [5:0]                ov_clr;

  // One deglitch filter per supply comparator
  genvar gi;
  generate
    for (gi = 0; gi < pfl_pkg::SUPPLY_CMPS; gi++) begin : g_dgl
      pfl_deglitch u_dgl (
        .clk        (clk),
        .rst        (rst),
        .level_raw  (supply_cmp[gi]),
        .level_filt (supply_filt[gi])
      );
    end
  endgenerate

  // Live status next value; the register below blanks it while the supply is locked out
  assign live_next.supply              = supply_filt;
  assign live_next.temp_warning_level  = temp_warning_level;
  assign live_next.temp_shutdown_level = temp_shutdown_level;
  assign live_next.system_power_good   = system_power_good & ~power_bad;
  assign live_next.fault_active        = fault_active;

  // Address decode; writes are decoded nowhere, so they change nothing
  assign rd_live = reg_req.rd && (reg_req.addr == pfl_pkg::LIVE_STATUS_OFS);
  assign rd_uv   = reg_req.rd && (reg_req.addr == pfl_pkg::UV_FLAGS_OFS);
  assign rd_ov   = reg_req.rd && (reg_req.addr == pfl_pkg::OV_FLAGS_OFS);

  // Flag words with reserved low bits tied off
  assign uv_word = {uv_reg, pfl_pkg::RSVD_BITS};
  assign ov_word = {ov_reg, pfl_pkg::RSVD_BITS};

  // Read clears every flag bit it returned
  assign uv_clr = rd_uv ? 6'h3f : 6'h00;
  assign ov_clr = rd_ov ? 6'h3f : 6'h00;

  // Sticky flags; a fresh event wins over the clearing read
  assign uv_next = (uv_reg & ~uv_clr) | uv_event;
  assign ov_next = (ov_reg & ~ov_clr) | ov_event;

  // Read mux; unmapped offsets and a locked-out supply read as zero
  assign rdata_next = supply_lockout ? pfl_pkg::UNMAPPED_DATA :
                      rd_live        ? live_reg :
                      rd_uv          ? uv_word :
                      rd_ov          ? ov_word :
                                       pfl_pkg::UNMAPPED_DATA;

  // Live status register, read-only from the port
  always_ff @(posedge clk) begin
    if (rst || supply_lockout) begin
      live_reg <= pfl_pkg::LIVE_STATUS_RST;
    end else begin
      live_reg <= live_next;
    end
  end

  // Flag registers; lockout and fuse reload take priority over events
  always_ff @(posedge clk) begin
    if (rst || supply_lockout) begin
      uv_reg <= pfl_pkg::RAIL_FLAGS_RST;
      ov_reg <= pfl_pkg::RAIL_FLAGS_RST;
    end else if (factory_fuse_load) begin
      uv_reg <= pfl_pkg::RAIL_FLAGS_FUSE;
      ov_reg <= pfl_pkg::RAIL_FLAGS_FUSE;
    end else begin
      uv_reg <= uv_next;
      ov_reg <= ov_next;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      valid_reg  <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= reg_req.rd;
      valid_reg  <= ~supply_lockout;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign regs_valid = valid_reg;

  // Helper: run length of high samples on the monitor comparator
  logic [11:0] mon_hi_cnt;
  always_ff @(posedge clk) begin
    if (rst || !supply_cmp.sys_monitor_level) begin
      mon_hi_cnt <= 12'h000;
    end else if (mon_hi_cnt != 12'hfff) begin
      mon_hi_cnt <= mon_hi_cnt + 12'h001;
    end
  end

  // Monitor bit never rises before a full deglitch run
  mon_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(live_reg.supply.sys_monitor_level) |->
      ($past(mon_hi_cnt) >= 12'(pfl_pkg::DEGLITCH_CYC)))
    else $error("monitor bit rose before deglitch time");

  // Warning bit drops two cycles after its comparator
  supply_fall_a: assert property (
    @(posedge clk) disable iff (rst)
    !supply_cmp.supply_warning_level |-> ##2 !live_reg.supply.supply_warning_level)
    else $error("warning bit did not fall");

  // Overvoltage bits drop two cycles after both their comparators are low
  ov_bits_fall_a: assert property (
    @(posedge clk) disable iff (rst)
    (!supply_cmp.good_overvoltage_level && !supply_cmp.input_overvoltage_level) |->
      ##2 (!live_reg.supply.good_overvoltage_level && !live_reg.supply.input_overvoltage_level))
    else $error("overvoltage bits did not fall");

  // Temperature bits follow the comparators one cycle later
  temp_bits_a: assert property (
    @(posedge clk) disable iff (rst)
    (!rst && !supply_lockout) |=>
      (live_reg.temp_warning_level == $past(temp_warning_level)) &&
      (live_reg.temp_shutdown_level == $past(temp_shutdown_level)))
    else $error("temperature bits wrong");

  // Power good reads zero under power bad
  power_good_a: assert property (
    @(posedge clk) disable iff (rst)
    $past(power_bad) |-> !live_reg.system_power_good)
    else $error("power good set during power bad");

  // Fault summary tracks the fault input
  fault_bit_a: assert property (
    @(posedge clk) disable iff (rst)
    (!rst && !supply_lockout) |=> (live_reg.fault_active == $past(fault_active)))
    else $error("fault bit not tracking");

  // Steps of a clearing read of the undervoltage flags
  sequence uv_clean_read_s;
    rd_uv && !supply_lockout && !factory_fuse_load && (uv_event == 6'h00);
  endsequence
  sequence uv_cleared_s;
    (reg_rdata == {$past(uv_reg), 2'h0}) && reg_rvalid && (uv_reg == 6'h00);
  endsequence

  // Read returns the latched flags and leaves them clear
  read_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    uv_clean_read_s |=> uv_cleared_s)
    else $error("undervoltage read did not return and clear");

  // Event during a clearing read still sets its flag
  event_wins_a: assert property (
    @(posedge clk) disable iff (rst)
    (rd_uv && uv_event.linear2 && !supply_lockout && !factory_fuse_load) |=>
      uv_reg.linear2)
    else $error("event lost under clearing read");

  // Flag survives rail recovery until read
  flag_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (uv_reg.rail1 && !rd_uv && !supply_lockout && !factory_fuse_load) |=> uv_reg.rail1)
    else $error("undervoltage flag dropped without read");

  // Reserved bits of a flag read are zero
  rsvd_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    (rd_uv || rd_ov) |=> (reg_rdata[1:0] == 2'h0))
    else $error("reserved bits not zero");

  // Lockout blanks every register and the valid flag
  lockout_a: assert property (
    @(posedge clk) disable iff (rst)
    supply_lockout |=> (live_reg == 8'h00) && (uv_reg == 6'h00) &&
                       (ov_reg == 6'h00) && !regs_valid)
    else $error("registers not blanked under lockout");

  // Fuse reload restores the factory value
  fuse_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (factory_fuse_load && !supply_lockout) |=>
      (uv_reg == pfl_pkg::RAIL_FLAGS_FUSE) && (ov_reg == pfl_pkg::RAIL_FLAGS_FUSE))
    else $error("fuse reload did not restore flags");

  // Monitor bit drops two cycles after its comparator
  mon_fall_a: assert property (
    @(posedge clk) disable iff (rst)
    !supply_cmp.sys_monitor_level |-> ##2 !live_reg.supply.sys_monitor_level)
    else $error("monitor bit did not fall");

  // Input overvoltage bit drops two cycles after its comparator
  inov_fall_a: assert property (
    @(posedge clk) disable iff (rst)
    !supply_cmp.input_overvoltage_level |-> ##2 !live_reg.supply.input_overvoltage_level)
    else $error("input overvoltage bit did not fall");

  // Helper run counters, one per comparator so no rise hides behind another
  genvar ri;
  generate
    for (ri = 0; ri < pfl_pkg::SUPPLY_CMPS; ri++) begin : g_rise
      logic [11:0] hi_cnt;
      always_ff @(posedge clk) begin
        if (rst || !supply_cmp[ri]) begin
          hi_cnt <= 12'h000;
        end else if (hi_cnt != 12'hfff) begin
          hi_cnt <= hi_cnt + 12'h001;
        end
      end

      // No supply bit rises before a full deglitch run of its comparator
      supply_rise_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(live_reg.supply[ri]) |-> ($past(hi_cnt) >= 12'(pfl_pkg::DEGLITCH_CYC)))
        else $error("supply bit rose before deglitch time");
    end
  endgenerate

  // Writes are dropped, so both flag registers stay as they were
  write_ignored_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.wr && !reg_req.rd && !supply_lockout && !factory_fuse_load &&
     (uv_event == 6'h00) && (ov_event == 6'h00)) |=>
      (uv_reg == $past(uv_reg)) && (ov_reg == $past(ov_reg)))
    else $error("write changed a flag register");

  // Reset leaves every register and the answer port at zero
  reset_zero_a: assert property (
    @(posedge clk)
    rst |=> (live_reg == pfl_pkg::LIVE_STATUS_RST) && (uv_reg == pfl_pkg::RAIL_FLAGS_RST) &&
            (ov_reg == pfl_pkg::RAIL_FLAGS_RST) && !reg_rvalid && !regs_valid)
    else $error("registers not cleared by reset");

  // Steps of a clearing read of the overvoltage flags
  sequence ov_clean_read_s;
    rd_ov && !supply_lockout && !factory_fuse_load && (ov_event == 6'h00);
  endsequence
  sequence ov_cleared_s;
    (reg_rdata == {$past(ov_reg), pfl_pkg::RSVD_BITS}) && reg_rvalid && (ov_reg == 6'h00);
  endsequence

  // Overvoltage read returns the latched flags and leaves them clear
  ov_read_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    ov_clean_read_s |=> ov_cleared_s)
    else $error("overvoltage read did not return and clear");

  // An undervoltage event outside lockout and fuse reload leaves its flag set one cycle later
  uv_set_a: assert property (
    @(posedge clk) disable iff (rst)
    ((uv_event != 6'h00) && !supply_lockout && !factory_fuse_load) |=>
      ((uv_reg & $past(uv_event)) == $past(uv_event)))
    else $error("undervoltage event did not set its flag");

  // An overvoltage event outside lockout and fuse reload leaves its flag set one cycle later
  ov_set_a: assert property (
    @(posedge clk) disable iff (rst)
    ((ov_event != 6'h00) && !supply_lockout && !factory_fuse_load) |=>
      ((ov_reg & $past(ov_event)) == $past(ov_event)))
    else $error("overvoltage event did not set its flag");

  // Every read is answered one cycle later, even under lockout
  rvalid_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_req.rd |=> reg_rvalid)
    else $error("read not answered");

  // No answer appears without a read
  rvalid_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !reg_req.rd |=> !reg_rvalid)
    else $error("answer without a read");

  // A read under lockout answers zero, since the contents are not valid
  lockout_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.rd && supply_lockout) |=> (reg_rdata == pfl_pkg::UNMAPPED_DATA))
    else $error("read under lockout returned data");

  // A live status read returns the register as it stood
  live_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (rd_live && !supply_lockout) |=> (reg_rdata == $past(live_reg)))
    else $error("live status read returned wrong data");

endmodule : pfl_status_flags

// File: test/pfl_host_model.sv
// Host side model issuing byte accesses to the flag bank
`timescale 1ns/10ps
module pfl_host_model (
  // Clock
  input  wire logic             clk,
  // Byte access port toward the bank
  output pfl_pkg::pfl_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic             reg_rvalid
);
  initial reg_req = '0;

  // One access; gap idles first so slow hosts are seen as well
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        input int gap, output logic [7:0] data);
    int n;
    n = 0;
    data = 8'hxx;
    repeat (gap + 1) @(posedge clk);
    reg_req <= '{rd: ~wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge clk);
    // Idle fields scrambled so no stale address looks valid
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    while (!wr && n < 4) begin
      @(negedge clk);
      if (reg_rvalid === 1'b1) begin
        data = reg_rdata;
        n = 4;
      end
      n++;
    end
  endtask : access
endmodule : pfl_host_model

// File: test/tb_top.sv
// Self-checking bench of the status and fault flag bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_top;
  logic                     clk, rst, tw, ts, pg, pb, fa, lock, fuse, rvalid, valid;
  pfl_pkg::pfl_supply_cmp_t cmp;
  pfl_pkg::pfl_rails_t      uv, ov;
  pfl_pkg::pfl_reg_req_t    req;
  logic [7:0]               rdata, d;
  int                       mismatches = 0;
  int                       num_checks = 0;
  // Rows: temp warn, temp shutdown, good, bad, fault, expected live byte
  typedef struct packed { logic [4:0] in; logic [7:0] exp; } pfl_row_t;
  pfl_row_t rows [6] = '{'{5'h10, 8'h08}, '{5'h08, 8'h04}, '{5'h04, 8'h02},
                         '{5'h06, 8'h00}, '{5'h01, 8'h01}, '{5'h1d, 8'h0f}};

  pfl_status_flags u_pfl_status_flags (.clk(clk), .rst(rst), .supply_cmp(cmp),
    .temp_warning_level(tw), .temp_shutdown_level(ts), .supply_lockout(lock),
    .system_power_good(pg), .power_bad(pb), .fault_active(fa), .uv_event(uv),
    .ov_event(ov), .factory_fuse_load(fuse), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .regs_valid(valid));
  pfl_host_model u_pfl_host_model (.clk(clk), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    u_pfl_host_model.access(1'b0, addr, 8'h00, 2, got);
    `CHK("read data", exp, got)
  endtask : chk_rd

  // One cycle event pulse on both flag inputs
  task automatic pulse(input logic [5:0] u, input logic [5:0] o);
    @(posedge clk);
    uv <= u;
    ov <= o;
    @(posedge clk);
    uv <= '0;
    ov <= '0;
  endtask : pulse

  // Watchdog, run needs about 2100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst, tw, ts, pg, pb, fa, lock, fuse} = 8'h80;
    cmp = '0;
    uv = '0;
    ov = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) chk_rd(8'(a), 8'h00);
    `CHK("regs valid", 1'b1, valid)
    foreach (rows[i]) begin
      @(posedge clk);
      {tw, ts, pg, pb, fa} <= rows[i].in;
      chk_rd(8'h00, rows[i].exp);
    end
    u_pfl_host_model.access(1'b1, 8'h00, 8'hff, 0, d);
    chk_rd(8'h00, 8'h0f);
    // Glitch restarts two counts; the other two comparators run on
    @(posedge clk);
    cmp <= 4'hf;
    repeat (600) @(posedge clk);
    cmp <= 4'h5;
    repeat (2) @(posedge clk);
    cmp <= 4'hf;
    repeat (1000) @(posedge clk);
    chk_rd(8'h00, 8'h5f);
    repeat (300) @(posedge clk);
    chk_rd(8'h00, 8'hff);
    @(posedge clk);
    cmp <= 4'h0;
    {tw, ts, pg, pb, fa} <= 5'h0;
    chk_rd(8'h00, 8'h00);
    // Sticky flags survive recovery, clear on read
    pulse(6'h21, 6'h12);
    chk_rd(8'h01, 8'h84);
    chk_rd(8'h02, 8'h48);
    chk_rd(8'h01, 8'h00);
    chk_rd(8'h02, 8'h00);
    // Event ending on the clearing read's edge must not be lost
    @(posedge clk);
    uv <= 6'h3f;
    fork
      chk_rd(8'h01, 8'hfc);
      begin
        repeat (4) @(posedge clk);
        uv <= '0;
      end
    join
    chk_rd(8'h01, 8'hfc);
    chk_rd(8'h01, 8'h00);
    pulse(6'h00, 6'h3f);
    u_pfl_host_model.access(1'b1, 8'h02, 8'h03, 0, d);
    chk_rd(8'h02, 8'hfc);
    chk_rd(8'h05, 8'h00);
    // Lockout hides and wipes the registers
    pulse(6'h3f, 6'h3f);
    @(posedge clk);
    lock <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("regs valid", 1'b0, valid)
    chk_rd(8'h01, 8'h00);
    @(posedge clk);
    lock <= 1'b0;
    chk_rd(8'h02, 8'h00);
    `CHK("regs valid", 1'b1, valid)
    pulse(6'h01, 6'h00);
    @(posedge clk);
    fuse <= 1'b1;
    @(posedge clk);
    fuse <= 1'b0;
    chk_rd(8'h01, 8'h00);
    // Reset in mid-run wipes the flags and silences the answer port
    pulse(6'h3f, 6'h3f);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("regs valid", 1'b0, valid)
    `CHK("read valid", 1'b0, rvalid)
    rst <= 1'b0;
    chk_rd(8'h01, 8'h00);
    chk_rd(8'h02, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
